/* asfm_host.sv */
// Host controller model: an AXI4-Lite master that reads and writes monitor words.
// Assumes one clock shared with the monitor and a caller that invokes one task at a time.
`timescale 1ns/1ps
`default_nettype none
module asfm_host (
	// Clock.
	input  wire logic        aclk,
	// Write address and data channels.
	output logic             awvalid,
	input  wire logic        awready,
	output logic [7:0]       awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	// Write response channel.
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic [1:0]  bresp,
	// Read channels.
	output logic             arvalid,
	input  wire logic        arready,
	output logic [7:0]       araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	// All master outputs idle at time zero.
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		{awaddr, araddr, wdata, wstrb} <= 52'h0;
	end

	// One write; the first edge keeps a new request apart from the last release.
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
			output bit late);
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hf;
		bready  <= 1'b1;
		late = 1'b1;
		r = 2'h3;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			// Released lines show the inverse so no stale value passes for live data.
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				late = 1'b0;
				break;
			end
		end
	endtask : write

	// One read; rready is held until the data are sampled.
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
			output bit late);
		int n;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		late = 1'b1;
		d = 32'h0;
		r = 2'h3;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				late = 1'b0;
				break;
			end
		end
	endtask : read
endmodule : asfm_host
`default_nettype wire

/* asfm_monitor.sv */
// Axis status flag monitor: status word, target value monitor, AXI4-Lite slave.
// Assumes the motion logic on the same clock supplies mode, events and distance.
`timescale 1ns/1ps
`default_nettype none
module asfm_monitor #(
	parameter int MON_PERIOD = asfm_pkg::MON_CYCLES
) (
	// Clock, reset and clock enable.
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   ce,
	// Motion logic status.
	input  wire asfm_pkg::asfm_mode_t   mode,
	input  wire asfm_pkg::asfm_evt_t    evt,
	input  wire logic                   continuous_path_pattern,
	input  wire logic [31:0]            positioning_address_or_amount,
	input  wire logic [31:0]            remaining_distance,
	// AXI4-Lite write address and data.
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [7:0]             s_axi_araddr,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	// Interrupt, high while an unmasked event is pending.
	output logic                        irq
);
	// Refuse a monitoring period the divider cannot serve.
	initial begin
		if (MON_PERIOD < 2 || MON_PERIOD > 65535) begin
			$error("asfm_monitor: MON_PERIOD out of range");
		end
	end

	// All state of the monitor.
	typedef struct packed {
		logic [15:0] status;     // Axis status flags.
		logic [31:0] target;     // Target value monitor.
		logic [2:0]  irq_sts;    // Sticky flag-rise events.
		logic [2:0]  irq_msk;    // Event mask.
		logic [31:0] oshift;     // Origin shift amount.
		logic [31:0] inpos;      // In-position range.
		logic        aw_got;     // Write address held.
		logic [7:0]  aw_addr;    // Held write address.
		logic        w_got;      // Write data held.
		logic [31:0] w_data;     // Held write data.
		logic [3:0]  w_strb;     // Held write strobes.
		logic        bvalid;     // Write response pending.
		logic [1:0]  bresp;      // Write response code.
		logic        rvalid;     // Read data pending.
		logic [31:0] rdata;      // Read data.
		logic [1:0]  rresp;      // Read response code.
	} asfm_st_t;

	asfm_st_t st;      // Current state.
	asfm_st_t next_st; // Next state.
	logic     tick;    // Monitoring-cycle pulse.
	logic     spd;     // Speed control in effect.
	logic     wr_go;   // Write takes effect this cycle.
	logic     rd_go;   // Read is accepted this cycle.
	logic [2:0] rise;  // Status flags that rise this cycle.

	// Monitoring-cycle divider.
	// It shares the clock enable, so a frozen block also freezes the cycle count.
	asfm_tick #(.PERIOD(MON_PERIOD)) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.tick    (tick)
	);

	// Speed control is in effect only in the pure or switching speed phases.
	assign spd = (mode == asfm_pkg::ASFM_SPEED) || (mode == asfm_pkg::ASFM_SP_SPEED) ||
		(mode == asfm_pkg::ASFM_PS_SPEED);

	// Handshake readiness; one write and one read at a time.
	assign s_axi_awready = !st.aw_got && !st.bvalid;
	assign s_axi_wready  = !st.w_got && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign wr_go = st.aw_got && st.w_got && !st.bvalid;
	assign rd_go = s_axi_arvalid && !st.rvalid;

	// Next-state logic for flags, target, interrupt and bus.
	always_comb begin
		next_st = st;
		rise = 3'h0;
		// Speed flag follows the speed phase; off in position, manual and idle.
		next_st.status[asfm_pkg::BIT_SPEED_MODE] = spd;
		// Latch sets when position control takes over in speed-then-position.
		if (st.status[asfm_pkg::BIT_SPEED_MODE] && mode == asfm_pkg::ASFM_SP_POSITION) begin
			next_st.status[asfm_pkg::BIT_SWITCH_LAT] = 1'b1;
		end
		// Latch clears on the next entry and in jog or handwheel operation.
		if (evt.next_entry || mode == asfm_pkg::ASFM_MANUAL) begin
			next_st.status[asfm_pkg::BIT_SWITCH_LAT] = 1'b0;
		end
		// In-position check once per cycle, suspended in speed control.
		if (continuous_path_pattern || mode == asfm_pkg::ASFM_MANUAL) begin
			next_st.status[asfm_pkg::BIT_IN_POS] = 1'b0;
		end else if (tick && !spd) begin
			next_st.status[asfm_pkg::BIT_IN_POS] = (remaining_distance <= st.inpos);
		end
		// Target value loads at the start of each phase and drops to zero after.
		if (evt.pos_start || evt.cur_change) begin
			next_st.target = positioning_address_or_amount;
		end else if (evt.shift_start) begin
			next_st.target = st.oshift;
		end else if (evt.action_end || mode == asfm_pkg::ASFM_IDLE || spd ||
			mode == asfm_pkg::ASFM_MANUAL) begin
			next_st.target = asfm_pkg::RST_WORD;
		end
		// Rising flags are events; a set in the clearing cycle wins.
		rise = next_st.status[2:0] & ~st.status[2:0];
		// Write channel capture.
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		// Write commit; the monitors refuse writes with an error.
		if (wr_go) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = asfm_pkg::RESP_OKAY;
			case (st.aw_addr)
				asfm_pkg::OFS_IRQ_MSK: begin
					if (st.w_strb[0]) begin
						next_st.irq_msk = st.w_data[2:0];
					end
				end
				asfm_pkg::OFS_OSHIFT: begin
					for (int i = 0; i < 4; i++) begin
						if (st.w_strb[i]) next_st.oshift[i*8 +: 8] = st.w_data[i*8 +: 8];
					end
				end
				asfm_pkg::OFS_INPOS: begin
					for (int i = 0; i < 4; i++) begin
						if (st.w_strb[i]) next_st.inpos[i*8 +: 8] = st.w_data[i*8 +: 8];
					end
				end
				default: begin
					// Monitor words, the event register and holes take no writes.
					next_st.bresp = asfm_pkg::RESP_SLVERR;
				end
			endcase
		end
		// The master has taken the response; the write side is free again.
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read returns a whole registered word, never a half-updated one.
		if (rd_go) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = asfm_pkg::RESP_OKAY;
			case (s_axi_araddr)
				asfm_pkg::OFS_STATUS:  next_st.rdata = {16'h0000, st.status};
				asfm_pkg::OFS_TARGET:  next_st.rdata = st.target;
				asfm_pkg::OFS_IRQ_STS: begin
					next_st.rdata = {29'h0000_0000, st.irq_sts};
					// Reading clears the events; a rise in this cycle is merged in below.
					next_st.irq_sts = 3'h0;
				end
				asfm_pkg::OFS_IRQ_MSK: next_st.rdata = {29'h0000_0000, st.irq_msk};
				asfm_pkg::OFS_OSHIFT:  next_st.rdata = st.oshift;
				asfm_pkg::OFS_INPOS:   next_st.rdata = st.inpos;
				default: begin
					next_st.rdata = asfm_pkg::RST_WORD;
					next_st.rresp = asfm_pkg::RESP_SLVERR;
				end
			endcase
		end
		// The master has taken the data; the next read may be accepted.
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// New events set after any read clear.
		next_st.irq_sts = next_st.irq_sts | rise;
	end

	// Register the state; reset clears every flag, the clock enable freezes all.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.status <= asfm_pkg::RST_STATUS;
			st.irq_msk <= asfm_pkg::RST_MASK;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs straight from the state.
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata  = st.rdata;
	assign s_axi_rresp  = st.rresp;
	// Level interrupt: high while any unmasked event bit is set.
	assign irq = |(st.irq_sts & st.irq_msk);

	// Each assertion checks its rule on the edge after the cause is sampled.
	// Reset disables them, so the cleared state is never judged against stale history.
	// Speed flag tracks the speed phase one cycle later.
	speed_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> st.status[asfm_pkg::BIT_SPEED_MODE] == $past(spd)) else $error("speed flag wrong");
	// Speed flag low in position or manual modes.
	speed_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (mode == asfm_pkg::ASFM_MANUAL || mode == asfm_pkg::ASFM_POSITION)
		|=> !st.status[asfm_pkg::BIT_SPEED_MODE]) else $error("speed flag not off");
	// Switching phase: flag follows the speed phase only.
	switch_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && mode == asfm_pkg::ASFM_PS_POSITION |=> !st.status[asfm_pkg::BIT_SPEED_MODE])
		else $error("flag on in position phase");
	// Named sequence: speed phase then position phase.
	sequence sp_switch_s;
		ce && mode == asfm_pkg::ASFM_SP_SPEED ##1 ce && mode == asfm_pkg::ASFM_SP_POSITION;
	endsequence
	// The speed flag drops on the edge after the switch to position control.
	speed_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sp_switch_s |=> !st.status[asfm_pkg::BIT_SPEED_MODE]) else $error("speed flag held");
	// The latch sets on the edge after position control takes over, unless a new entry clears it.
	latch_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sp_switch_s ##0 !evt.next_entry
		|=> st.status[asfm_pkg::BIT_SWITCH_LAT]) else $error("latch not set");
	// A new entry or jog and handwheel operation clear the latch; the clear wins.
	latch_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (evt.next_entry || mode == asfm_pkg::ASFM_MANUAL)
		|=> !st.status[asfm_pkg::BIT_SWITCH_LAT]) else $error("latch not cleared");
	// On a tick outside speed control the flag compares distance with the range.
	inpos_eval_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && tick && !spd && !continuous_path_pattern && mode != asfm_pkg::ASFM_MANUAL
		|=> st.status[asfm_pkg::BIT_IN_POS] == ($past(remaining_distance) <= $past(st.inpos)))
		else $error("in-position wrong");
	// Continuous path entries keep the in-position flag low.
	inpos_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && continuous_path_pattern |=> !st.status[asfm_pkg::BIT_IN_POS])
		else $error("in-position during path");
	// Between ticks the in-position flag holds.
	inpos_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !tick && !continuous_path_pattern && mode != asfm_pkg::ASFM_MANUAL
		|=> $stable(st.status[asfm_pkg::BIT_IN_POS])) else $error("in-position off-cycle");
	// In speed control the evaluation is suspended even on a tick.
	inpos_spd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && tick && spd && !continuous_path_pattern
		|=> $stable(st.status[asfm_pkg::BIT_IN_POS])) else $error("in-position evaluated in speed");
	// The target loads the active entry's address or amount at its start.
	target_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (evt.pos_start || evt.cur_change) |=> st.target == $past(positioning_address_or_amount))
		else $error("target not loaded");
	// The origin shift phase loads the configured shift amount.
	target_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && evt.shift_start && !evt.pos_start && !evt.cur_change |=> st.target == $past(st.oshift))
		else $error("shift not loaded");
	// Jog and handwheel operation show a zero target.
	target_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && mode == asfm_pkg::ASFM_MANUAL && !evt.pos_start && !evt.cur_change && !evt.shift_start
		|=> st.target == 32'h0000_0000) else $error("target not zero");
	// Writes to the monitor words are refused with an error response.
	readonly_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && wr_go && (st.aw_addr == asfm_pkg::OFS_STATUS ||
		st.aw_addr == asfm_pkg::OFS_TARGET)
		|=> st.bresp == asfm_pkg::RESP_SLVERR) else $error("monitor word accepted a write");
	// A flag that rises leaves its event bit set, even across a read of the events.
	sticky_evt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (rise != 3'h0) |=> (st.irq_sts & $past(rise)) == $past(rise))
		else $error("event bit lost");
	// An unmasked rise raises the interrupt line on the next edge.
	irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !wr_go && ((rise & st.irq_msk) != 3'h0) |=> irq) else $error("interrupt not raised");

endmodule : asfm_monitor
`default_nettype wire

/* asfm_pkg.sv */
// Package for the axis status flag monitor: register map, field layout, timing.
// Assumes a 10 MHz module clock and an AXI4-Lite register bus with 32-bit data.
package asfm_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFS_STATUS  = 8'h00; // Axis status flags, read only.
	localparam logic [7:0] OFS_TARGET  = 8'h04; // Target value monitor, read only.
	localparam logic [7:0] OFS_IRQ_STS = 8'h08; // Sticky event bits, cleared on read.
	localparam logic [7:0] OFS_IRQ_MSK = 8'h0c; // Event mask, read and write.
	localparam logic [7:0] OFS_OSHIFT  = 8'h10; // Origin shift amount, read and write.
	localparam logic [7:0] OFS_INPOS   = 8'h14; // In-position range, read and write.

	// Field positions inside the status word.
	localparam int BIT_SPEED_MODE = 0; // Speed control active.
	localparam int BIT_SWITCH_LAT = 1; // Speed to position switchover latched.
	localparam int BIT_IN_POS     = 2; // Within in-position range.

	// Reset values.
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [2:0]  RST_MASK   = 3'h0;

	// Monitoring cycle, in nanoseconds, and clock period.
	localparam int MON_CYCLE_NS = 900000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MON_CYCLES = MON_CYCLE_NS / CLK_PERIOD_NS;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Axis operation mode reported by the motion logic.
	typedef enum logic [2:0] {
		ASFM_IDLE        = 3'h0,
		ASFM_POSITION    = 3'h1,
		ASFM_SPEED       = 3'h2,
		ASFM_SP_SPEED    = 3'h3,
		ASFM_SP_POSITION = 3'h4,
		ASFM_PS_POSITION = 3'h5,
		ASFM_PS_SPEED    = 3'h6,
		ASFM_MANUAL      = 3'h7
	} asfm_mode_t;

	// Motion events from the motion logic, one-cycle pulses.
	typedef struct packed {
		logic       pos_start;     // Start of position control.
		logic       cur_change;    // Start of a current-value change.
		logic       shift_start;   // Start of the origin shift phase.
		logic       next_entry;    // Next positioning data entry begins.
		logic       action_end;    // Positioning action has finished.
	} asfm_evt_t;

endpackage : asfm_pkg

/* asfm_tick.sv */
// Monitoring-cycle tick generator for the axis status flag monitor.
// Assumes one clock, a synchronous active-low reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module asfm_tick #(
	parameter int PERIOD = asfm_pkg::MON_CYCLES
) (
	// Clock and control.
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// Tick output, one cycle per period.
	output logic      tick
);
	// Refuse a period the counter cannot serve.
	initial begin
		if (PERIOD < 2 || PERIOD > 65535) begin
			$error("asfm_tick: PERIOD out of range");
		end
	end

	// All state of the divider.
	typedef struct packed {
		logic [15:0] cnt;  // Cycles since the last tick.
		logic        tick; // Registered tick.
	} asfm_tick_st_t;

	asfm_tick_st_t st;      // Current state.
	asfm_tick_st_t next_st; // Next state.

	// Count cycles and pulse at the end of each period.
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 16'(PERIOD - 1)) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	// Register the state; the clock enable freezes it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule : asfm_tick
`default_nettype wire

/* tb.sv */
// Testbench for the axis status flag monitor: motion stimulus and register checks.
// Assumes the host model for bus traffic and a shortened monitoring period.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int MP = 10; // Shortened monitoring period in clock cycles.
	logic aclk, aresetn, ce, cpp, irq;
	asfm_pkg::asfm_mode_t mode;
	asfm_pkg::asfm_evt_t evt;
	logic [31:0] pa, rem, wd, rd_d;
	logic [7:0] awa, ara;
	logic [3:0] ws;
	logic [1:0] br, rr;
	logic awv, awr, wv, wr_r, bv, bq, arv, arr, rv, rq;
	int n_errors, checks, i;

	// Free-running 10 MHz clock.
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;

	asfm_monitor #(.MON_PERIOD(MP)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .mode(mode),
		.evt(evt), .continuous_path_pattern(cpp), .positioning_address_or_amount(pa),
		.remaining_distance(rem), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_bresp(br), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rq),
		.s_axi_rdata(rd_d), .s_axi_rresp(rr), .irq(irq));
	asfm_host host (.aclk(aclk), .awvalid(awv), .awready(awr), .awaddr(awa), .wvalid(wv),
		.wready(wr_r), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(bq), .bresp(br),
		.arvalid(arv), .arready(arr), .araddr(ara), .rvalid(rv), .rready(rq), .rdata(rd_d),
		.rresp(rr));

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// Compares one value and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// A bus wait that ran out counts as a mismatch and ends the run.
	task automatic late_stop(input bit late);
		if (late) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
			report_and_stop();
		end
	endtask : late_stop

	// Reads a register and compares data and response.
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bit late;
		host.read(a, d, r, late);
		late_stop(late);
		chk({30'h0, r}, {30'h0, er});
		chk(d, e);
	endtask : rd

	// Writes a register and compares the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit late;
		host.write(a, d, r, late);
		late_stop(late);
		chk({30'h0, r}, {30'h0, er});
	endtask : wr

	// Changes the axis mode and lets the flags settle.
	task automatic setm(input asfm_pkg::asfm_mode_t m);
		@(posedge aclk);
		mode <= m;
		repeat (2) @(posedge aclk);
	endtask : setm

	// Sends one motion event pulse.
	task automatic pulse(input asfm_pkg::asfm_evt_t e);
		@(posedge aclk);
		evt <= e;
		@(posedge aclk);
		evt <= '0;
	endtask : pulse

	// Main sequence.
	initial begin
		{aresetn, cpp, pa, rem} <= {1'b0, 1'b0, 32'h0, 32'hffff_ffff};
		{ce, evt} <= {1'b1, 5'h00};
		mode <= asfm_pkg::ASFM_IDLE;
		{n_errors, checks} = {32'sd0, 32'sd0};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, read-only words and an unmapped place.
		rd(asfm_pkg::OFS_STATUS, 32'h0, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_TARGET, 32'h0, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_IRQ_STS, 32'h0, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_IRQ_MSK, 32'h0, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_OSHIFT, 32'h0, asfm_pkg::RESP_OKAY);
		rd(8'h18, 32'h0, asfm_pkg::RESP_SLVERR);
		wr(asfm_pkg::OFS_STATUS, 32'hffff_ffff, asfm_pkg::RESP_SLVERR);
		wr(asfm_pkg::OFS_TARGET, 32'hffff_ffff, asfm_pkg::RESP_SLVERR);
		rd(asfm_pkg::OFS_STATUS, 32'h0, asfm_pkg::RESP_OKAY);
		wr(asfm_pkg::OFS_OSHIFT, 32'h0000_0abc, asfm_pkg::RESP_OKAY);
		wr(asfm_pkg::OFS_INPOS, 32'h0000_0064, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_INPOS, 32'h0000_0064, asfm_pkg::RESP_OKAY);
		$display("test registers done");
		// Every mode in order; the latch sets entering the position phase, manual clears it.
		for (i = 0; i < 8; i++) begin
			setm(asfm_pkg::asfm_mode_t'(i));
			rd(asfm_pkg::OFS_STATUS, {30'h0, (i >= 4 && i <= 6), (i == 2 || i == 3 || i == 6)},
				asfm_pkg::RESP_OKAY);
		end
		setm(asfm_pkg::ASFM_SP_SPEED);
		setm(asfm_pkg::ASFM_SP_POSITION);
		rd(asfm_pkg::OFS_STATUS, 32'h2, asfm_pkg::RESP_OKAY);
		pulse(5'b00010);
		rd(asfm_pkg::OFS_STATUS, 32'h0, asfm_pkg::RESP_OKAY);
		$display("test mode flags done");
		// In-position around the range boundary, with continuous path, and during speed.
		setm(asfm_pkg::ASFM_POSITION);
		rem <= 32'd100;
		repeat (MP + 3) @(posedge aclk);
		rd(asfm_pkg::OFS_STATUS, 32'h4, asfm_pkg::RESP_OKAY);
		rem <= 32'd101;
		repeat (MP + 3) @(posedge aclk);
		rd(asfm_pkg::OFS_STATUS, 32'h0, asfm_pkg::RESP_OKAY);
		{cpp, rem} <= {1'b1, 32'd0};
		repeat (MP + 3) @(posedge aclk);
		rd(asfm_pkg::OFS_STATUS, 32'h0, asfm_pkg::RESP_OKAY);
		{cpp, mode} <= {1'b0, asfm_pkg::ASFM_SPEED};
		repeat (2 * MP) @(posedge aclk);
		rd(asfm_pkg::OFS_STATUS, 32'h1, asfm_pkg::RESP_OKAY);
		$display("test in-position done");
		// Target loads on each start event in turn and returns to zero.
		setm(asfm_pkg::ASFM_POSITION);
		pa <= 32'h0000_1234;
		pulse(5'b10000);
		rd(asfm_pkg::OFS_TARGET, 32'h0000_1234, asfm_pkg::RESP_OKAY);
		pa <= 32'h0000_0055;
		pulse(5'b01000);
		rd(asfm_pkg::OFS_TARGET, 32'h0000_0055, asfm_pkg::RESP_OKAY);
		pulse(5'b00100);
		rd(asfm_pkg::OFS_TARGET, 32'h0000_0abc, asfm_pkg::RESP_OKAY);
		pulse(5'b00001);
		rd(asfm_pkg::OFS_TARGET, 32'h0, asfm_pkg::RESP_OKAY);
		$display("test target done");
		// Sticky events, clear on read, mask and interrupt line.
		rem <= 32'hffff_ffff;
		setm(asfm_pkg::ASFM_IDLE);
		repeat (MP + 3) @(posedge aclk);
		rd(asfm_pkg::OFS_IRQ_STS, 32'h7, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_IRQ_STS, 32'h0, asfm_pkg::RESP_OKAY);
		wr(asfm_pkg::OFS_IRQ_MSK, 32'h1, asfm_pkg::RESP_OKAY);
		setm(asfm_pkg::ASFM_SPEED);
		chk({31'h0, irq}, 32'h1);
		rd(asfm_pkg::OFS_IRQ_STS, 32'h1, asfm_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(asfm_pkg::OFS_IRQ_MSK, 32'h0, asfm_pkg::RESP_OKAY);
		setm(asfm_pkg::ASFM_IDLE);
		setm(asfm_pkg::ASFM_SPEED);
		chk({31'h0, irq}, 32'h0);
		rd(asfm_pkg::OFS_IRQ_STS, 32'h1, asfm_pkg::RESP_OKAY);
		$display("test interrupt done");
		// Clock enable low: a speed phase while frozen must leave no event behind.
		setm(asfm_pkg::ASFM_IDLE);
		ce <= 1'b0;
		mode <= asfm_pkg::ASFM_SPEED;
		repeat (5) @(posedge aclk);
		ce <= 1'b1;
		mode <= asfm_pkg::ASFM_IDLE;
		rd(asfm_pkg::OFS_IRQ_STS, 32'h0, asfm_pkg::RESP_OKAY);
		rd(asfm_pkg::OFS_STATUS, 32'h0, asfm_pkg::RESP_OKAY);
		$display("test clock enable done");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
